// >>> rtl/trigger_io_pkg.sv
// Package with constants, register map and types of the trigger I/O block.
package trigger_io_pkg;

  localparam int NUM_INPUTS   = 8;
  localparam int NUM_TARGETS  = 32;
  localparam int NUM_DET      = 2;
  localparam int NUM_RELAYS   = 2;
  localparam int NUM_TTL_OUT  = 2;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int DAC_W        = 16;

  // Clock and pulse qualification timing.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_MIN_MS    = 50;
  localparam int PULSE_REJECT_MS = 4;
  localparam int PULSE_ACCEPT_CYC = PULSE_REJECT_MS * 1000000 / CLK_PERIOD_NS + 1;
  localparam int PULSE_GUAR_CYC   = PULSE_MIN_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WIDTH_CNT_W      = 23;

  // Register offsets (byte addresses, one word each).
  localparam logic [ADDR_W-1:0] OFS_IN_MODE    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_ASSIGN0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TARGET_ST  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_TARGET_SET = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_OUT_CTRL   = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IN_LEVEL   = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_AO_CFG0    = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_AO_OFS0    = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_AO_CMD     = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_AO_OUT0    = 8'h64;

  // Target bit positions in the assignment mask.
  localparam int T_INJ_L     = 0;
  localparam int T_INJ_R     = 1;
  localparam int T_TRAY_HP_A = 2;
  localparam int T_TRAY_HP_B = 3;
  localparam int T_TRAY_LP_A = 4;
  localparam int T_TRAY_LP_B = 5;
  localparam int T_REAR_LP_A = 6;
  localparam int T_DET1_RUN  = 12;
  localparam int T_DET2_RUN  = 13;
  localparam int T_DET1_AOFS = 14;
  localparam int T_DET2_AOFS = 15;
  localparam int T_DET1_MARK = 16;
  localparam int T_DET2_MARK = 17;
  localparam int T_SUPP1     = 18;
  localparam int T_SUPP2     = 19;
  localparam int T_HEATER    = 20;
  localparam int T_RELAY1    = 21;
  localparam int T_RELAY2    = 22;
  localparam logic [NUM_TARGETS-1:0] SINGLE_ACTION_MASK = 32'h0003_c000;
  localparam logic [NUM_TARGETS-1:0] VALID_TARGET_MASK  = 32'h007f_ffff;

  // Reset values.
  localparam logic [NUM_TARGETS-1:0] TARGET_RST = 32'h0000_0000;
  localparam logic [15:0]            MODE_RST   = 16'h0000;

  // Full-scale level codes, for a signed output where 1.00 V is 32000.
  localparam logic signed [DAC_W-1:0] FS_10MV  = 16'sh0140;
  localparam logic signed [DAC_W-1:0] FS_100MV = 16'sh0c80;
  localparam logic signed [DAC_W-1:0] FS_1V    = 16'sh7d00;
  localparam int MARK_CYC = 100000;

  typedef enum logic [1:0] {
    CT_NORMAL_EDGE   = 2'h0,
    CT_INVERTED_EDGE = 2'h1,
    CT_NORMAL_PULSE  = 2'h2,
    CT_INVERTED_PULSE = 2'h3
  } ctrl_type_t;

  typedef enum logic [1:0] {
    CAL_NORMAL    = 2'h0,
    CAL_ZERO      = 2'h1,
    CAL_FULLSCALE = 2'h2
  } cal_t;

  typedef enum logic [1:0] {
    FSV_10MV  = 2'h0,
    FSV_100MV = 2'h1,
    FSV_1V    = 2'h2
  } fs_sel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_RELAYS-1:0] openWhenIdle;
    logic [NUM_RELAYS-1:0] closedWhenIdle;
  } relay_pins_t;

endpackage : trigger_io_pkg

// >>> rtl/instrument_trigger_io_control.sv
// Trigger input decoding, target control, analog output conditioning and relays.
`timescale 1ns/100ps
`default_nettype none
module instrument_trigger_io_control (
  input  wire logic                                       clock,
  input  wire logic                                       srst,
  input  wire trigger_io_pkg::reg_req_t                   regReq,
  output var  logic [trigger_io_pkg::DATA_W-1:0]          regRdata,
  input  wire logic [trigger_io_pkg::NUM_INPUTS-1:0]      trigIn,
  input  wire logic signed [trigger_io_pkg::DAC_W-1:0]    detSample [trigger_io_pkg::NUM_DET],
  output var  logic signed [trigger_io_pkg::DAC_W-1:0]    analogOut [trigger_io_pkg::NUM_DET],
  output var  logic [trigger_io_pkg::NUM_TARGETS-1:0]     targetState,
  output var  logic [trigger_io_pkg::NUM_DET-1:0]         autoOffsetPulse,
  output var  logic [trigger_io_pkg::NUM_TTL_OUT-1:0]     ttlOut,
  output var  trigger_io_pkg::relay_pins_t                relayPins
);
  import trigger_io_pkg::*;

  logic [NUM_INPUTS-1:0]  syncA_reg;
  logic [NUM_INPUTS-1:0]  syncB_reg;
  logic [NUM_INPUTS-1:0]  prevLevel_reg;
  logic [15:0]            mode_reg;
  logic [NUM_TARGETS-1:0] assign_reg [NUM_INPUTS];
  logic [NUM_INPUTS-1:0]  fireOn;
  logic [NUM_INPUTS-1:0]  fireOff;
  logic [NUM_TARGETS-1:0] onMask;
  logic [NUM_TARGETS-1:0] offMask;
  logic [NUM_TARGETS-1:0] target_reg;
  logic [NUM_TARGETS-1:0] target_next;
  logic [NUM_TTL_OUT-1:0] ttl_reg;
  logic [1:0]             fsSel_reg [NUM_DET];
  logic [1:0]             cal_reg [NUM_DET];
  logic                   negPol_reg [NUM_DET];
  logic [15:0]            range_reg [NUM_DET];
  logic [6:0]             offsetPct_reg [NUM_DET];
  logic [NUM_DET-1:0]     markReq;
  logic [NUM_DET-1:0]     swMark;
  logic [NUM_DET-1:0]     swAofs;

  wire logic wrHit = regReq.wr;

  // Two-flop synchroniser; only syncB_reg and its delayed copy prevLevel_reg are looked at.
  always_ff @(posedge clock) begin
    if (srst) begin
      syncA_reg     <= '1;
      syncB_reg     <= '1;
      prevLevel_reg <= '1;
    end else begin
      syncA_reg     <= trigIn;
      syncB_reg     <= syncA_reg;
      prevLevel_reg <= syncB_reg;
    end
  end

  // Per-input edge and pulse decoding.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
      logic [WIDTH_CNT_W-1:0] width_reg;
      logic                   inPulse_reg;
      ctrl_type_t             ct;
      logic                   rise;
      logic                   fall;
      logic                   actStart;
      logic                   actEnd;
      assign ct   = ctrl_type_t'(mode_reg[2*gi +: 2]);
      assign rise = syncB_reg[gi] & ~prevLevel_reg[gi];
      assign fall = ~syncB_reg[gi] & prevLevel_reg[gi];
      assign actStart = (ct == CT_NORMAL_PULSE) ? fall : rise;
      assign actEnd   = (ct == CT_NORMAL_PULSE) ? rise : fall;

      // Width counter runs while the active level is held in pulse modes.
      always_ff @(posedge clock) begin
        if (srst) begin
          width_reg   <= '0;
          inPulse_reg <= 1'b0;
        end else if (!ct[1] || actEnd) begin
          width_reg   <= '0;
          inPulse_reg <= 1'b0;
        end else if (actStart) begin
          width_reg   <= WIDTH_CNT_W'(1);
          inPulse_reg <= 1'b1;
        end else if (inPulse_reg && width_reg != '1) begin
          width_reg   <= width_reg + WIDTH_CNT_W'(1);
        end
      end

      always_comb begin
        fireOn[gi]  = 1'b0;
        fireOff[gi] = 1'b0;
        unique case (ct)
          CT_NORMAL_EDGE: begin
            fireOn[gi]  = fall;
            fireOff[gi] = rise;
          end
          CT_INVERTED_EDGE: begin
            fireOn[gi]  = rise;
            fireOff[gi] = fall;
          end
          CT_NORMAL_PULSE, CT_INVERTED_PULSE: begin
            // Fires once at the accept width; shorter pulses never reach it.
            fireOn[gi] = inPulse_reg && width_reg == WIDTH_CNT_W'(PULSE_ACCEPT_CYC);
          end
        endcase
      end
    end
  endgenerate

  // Masks are global, not tied to any run context.
  always_comb begin
    onMask  = '0;
    offMask = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (fireOn[i]) onMask = onMask | assign_reg[i];
      if (fireOff[i]) offMask = offMask | assign_reg[i];
    end
    onMask  = onMask & VALID_TARGET_MASK;
    offMask = offMask & VALID_TARGET_MASK & ~SINGLE_ACTION_MASK;
  end

  // Target state: set on activation, clear on deactivation; activation wins.
  // Injection bit 1 is load, 0 is inject; detector run bit 1 is running.
  always_comb begin
    target_next = target_reg & ~SINGLE_ACTION_MASK;
    if (wrHit && regReq.addr == OFS_TARGET_SET) begin
      target_next = regReq.wdata & VALID_TARGET_MASK & ~SINGLE_ACTION_MASK;
    end
    target_next = (target_next & ~offMask) | onMask;
  end

  always_ff @(posedge clock) begin
    if (srst) target_reg <= TARGET_RST;
    else target_reg <= target_next;
  end

  // Configuration registers.
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= MODE_RST;
      ttl_reg  <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) assign_reg[i] <= '0;
      for (int d = 0; d < NUM_DET; d++) begin
        fsSel_reg[d]     <= FSV_1V;
        cal_reg[d]       <= CAL_NORMAL;
        negPol_reg[d]    <= 1'b0;
        range_reg[d]     <= 16'h0001;
        offsetPct_reg[d] <= '0;
      end
    end else if (wrHit) begin
      if (regReq.addr == OFS_IN_MODE) mode_reg <= regReq.wdata[15:0];
      if (regReq.addr == OFS_OUT_CTRL) ttl_reg <= regReq.wdata[NUM_TTL_OUT-1:0];
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (regReq.addr == OFS_IN_ASSIGN0 + ADDR_W'(4 * i)) assign_reg[i] <= regReq.wdata;
      end
      for (int d = 0; d < NUM_DET; d++) begin
        if (regReq.addr == OFS_AO_CFG0 + ADDR_W'(4 * d)) begin
          fsSel_reg[d]  <= regReq.wdata[1:0];
          cal_reg[d]    <= regReq.wdata[3:2];
          negPol_reg[d] <= regReq.wdata[4];
          range_reg[d]  <= (regReq.wdata[31:16] == 16'h0000) ? 16'h0001 : regReq.wdata[31:16];
        end
        if (regReq.addr == OFS_AO_OFS0 + ADDR_W'(4 * d)) begin
          offsetPct_reg[d] <= (regReq.wdata[6:0] > 7'h64) ? 7'h64 : regReq.wdata[6:0];
        end
      end
    end
  end

  // Software mark and auto-offset commands, one-cycle.
  always_comb begin
    swMark = '0;
    swAofs = '0;
    if (wrHit && regReq.addr == OFS_AO_CMD) begin
      swMark = regReq.wdata[NUM_DET-1:0];
      swAofs = regReq.wdata[NUM_DET+3:4];
    end
    markReq = swMark | {onMask[T_DET2_MARK], onMask[T_DET1_MARK]};
  end

  always_ff @(posedge clock) begin
    if (srst) autoOffsetPulse <= '0;
    else autoOffsetPulse <= swAofs | {onMask[T_DET2_AOFS], onMask[T_DET1_AOFS]};
  end

  // Analog output conditioning per detector.
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DET; gd++) begin : g_ao
      logic [16:0]              markCnt_reg;
      logic signed [DAC_W-1:0]  fsLevel;
      logic signed [47:0]       scaled;
      logic signed [47:0]       total;
      logic signed [DAC_W-1:0]  outNext;

      always_ff @(posedge clock) begin
        if (srst) markCnt_reg <= '0;
        else if (markReq[gd]) markCnt_reg <= 17'(MARK_CYC);
        else if (markCnt_reg != '0) markCnt_reg <= markCnt_reg - 17'h00001;
      end

      always_comb begin
        unique case (fsSel_reg[gd])
          FSV_10MV:  fsLevel = FS_10MV;
          FSV_100MV: fsLevel = FS_100MV;
          default:   fsLevel = FS_1V;
        endcase
        // Reading equal to range gives full-scale level.
        scaled = (48'(detSample[gd]) * 48'(fsLevel)) / $signed({32'h0, range_reg[gd]});
        if (negPol_reg[gd]) scaled = -scaled;
        total = scaled + (48'(fsLevel) * $signed({41'h0, offsetPct_reg[gd]})) / 48'sd100;
        if (markCnt_reg != '0) total = total + 48'(fsLevel) / 48'sd10;
        if (total > 48'sd32767) outNext = 16'sh7fff;
        else if (total < -48'sd32768) outNext = 16'sh8000;
        else outNext = total[DAC_W-1:0];
        if (cal_reg[gd] == CAL_ZERO) outNext = '0;
        else if (cal_reg[gd] == CAL_FULLSCALE) outNext = fsLevel;
      end

      always_ff @(posedge clock) begin
        if (srst) analogOut[gd] <= '0;
        else analogOut[gd] <= outNext;
      end
    end
  endgenerate

  // Outputs and relay contacts.
  always_ff @(posedge clock) begin
    if (srst) begin
      targetState <= TARGET_RST;
      ttlOut      <= '0;
      relayPins   <= '{openWhenIdle: '0, closedWhenIdle: '1};
    end else begin
      targetState <= target_next;
      ttlOut      <= ttl_reg;
      relayPins   <= '{openWhenIdle:   {target_next[T_RELAY2], target_next[T_RELAY1]},
                       closedWhenIdle: ~{target_next[T_RELAY2], target_next[T_RELAY1]}};
    end
  end

  // Read port, data one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      regRdata <= '0;
      if (regReq.addr == OFS_IN_MODE) regRdata <= {16'h0, mode_reg};
      if (regReq.addr == OFS_TARGET_ST) regRdata <= target_reg;
      if (regReq.addr == OFS_OUT_CTRL) regRdata <= {30'h0, ttl_reg};
      if (regReq.addr == OFS_IN_LEVEL) regRdata <= {24'h0, syncB_reg};
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (regReq.addr == OFS_IN_ASSIGN0 + ADDR_W'(4 * i)) regRdata <= assign_reg[i];
      end
      for (int d = 0; d < NUM_DET; d++) begin
        if (regReq.addr == OFS_AO_CFG0 + ADDR_W'(4 * d)) begin
          regRdata <= {range_reg[d], 11'h0, negPol_reg[d], cal_reg[d], fsSel_reg[d]};
        end
        if (regReq.addr == OFS_AO_OFS0 + ADDR_W'(4 * d)) regRdata <= {25'h0, offsetPct_reg[d]};
        if (regReq.addr == OFS_AO_OUT0 + ADDR_W'(4 * d)) begin
          regRdata <= {{16{analogOut[d][DAC_W-1]}}, analogOut[d]};
        end
      end
    end else begin
      regRdata <= '0;
    end
  end

endmodule : instrument_trigger_io_control
`default_nettype wire

// >>> test/trigger_io_checker.sv
// Port checker for the trigger I/O block.
`timescale 1ns/100ps
`default_nettype none
module trigger_io_checker (
  input wire logic                                   clock,
  input wire logic                                   srst,
  input wire trigger_io_pkg::reg_req_t               regReq,
  input wire logic [trigger_io_pkg::DATA_W-1:0]      regRdata,
  input wire logic [trigger_io_pkg::NUM_INPUTS-1:0]  trigIn,
  input wire logic [trigger_io_pkg::NUM_TARGETS-1:0] targetState,
  input wire logic [trigger_io_pkg::NUM_DET-1:0]     autoOffsetPulse,
  input wire logic [trigger_io_pkg::NUM_TTL_OUT-1:0] ttlOut,
  input wire trigger_io_pkg::relay_pins_t            relayPins
);
  import trigger_io_pkg::*;
  logic [NUM_INPUTS-1:0] prevIn;
  logic [2:0]            quiet;
  // Counts cycles with no pin change and no register write.
  always_ff @(posedge clock) begin
    prevIn <= trigIn;
    if (srst || regReq.wr || trigIn != prevIn) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!regReq.rd |=> regRdata == '0)
    else $error("read data not zero outside a read");
  a_relay_pair: assert property (relayPins.closedWhenIdle == ~relayPins.openWhenIdle)
    else $error("relay contacts not complementary");
  a_single_unheld: assert property (targetState[17:16] != 2'h0 |=> targetState[17:16] == 2'h0)
    else $error("mark target held as state");
  a_unused_targets: assert property (targetState[31:23] == '0)
    else $error("unused target bits set");
  a_ttl_cause: assert property ($changed(ttlOut) |->
    $past(regReq.wr, 2) && $past(regReq.addr, 2) == OFS_OUT_CTRL)
    else $error("digital output changed without a write");
  a_target_quiet: assert property (quiet == 3'h7 |-> $stable(targetState))
    else $error("target state changed without cause");
  a_ofs_single: assert property (autoOffsetPulse[0] |=> !autoOffsetPulse[0])
    else $error("auto-offset pulse longer than one cycle");
  a_reset_clear: assert property ($fell(srst) |->
    targetState == '0 && relayPins.openWhenIdle == '0)
    else $error("state not cleared by reset");
  c_fire: cover property ($rose(targetState[0]));
  c_ofs: cover property (autoOffsetPulse[0]);
  c_ttl: cover property (ttlOut == 2'h2);
endmodule : trigger_io_checker
bind instrument_trigger_io_control trigger_io_checker chk (
  .clock(clock), .srst(srst), .regReq(regReq), .regRdata(regRdata), .trigIn(trigIn),
  .targetState(targetState), .autoOffsetPulse(autoOffsetPulse), .ttlOut(ttlOut),
  .relayPins(relayPins));
`default_nettype wire

// >>> test/trigger_source.sv
// Model of the outside instrument that drives the trigger inputs.
`timescale 1ns/100ps
`default_nettype none
module trigger_source (
  input  wire logic                                  clock,
  input  wire logic                                  setGo,
  input  wire logic [2:0]                            setLine,
  input  wire logic                                  setLevel,
  output var  logic [trigger_io_pkg::NUM_INPUTS-1:0] trigIn
);
  import trigger_io_pkg::*;
  logic [NUM_INPUTS-1:0] level = '1;
  // Lines idle high and change only right after a clock edge.
  always @(posedge clock) begin
    if (setGo) begin
      level[setLine] <= setLevel;
    end
  end
  assign trigIn = level;
endmodule : trigger_source
`default_nettype wire

// >>> test/instrument_trigger_io_control_test.sv
// Self-checking bench for the trigger I/O block.
`timescale 1ns/100ps
`default_nettype none
module instrument_trigger_io_control_test;
  import trigger_io_pkg::*;
  logic                    clock = 1'b0;
  logic                    srst = 1'b1;
  reg_req_t                regReq = '0;
  logic [DATA_W-1:0]       regRdata;
  logic [NUM_INPUTS-1:0]   trigIn;
  logic signed [DAC_W-1:0] detSample [NUM_DET] = '{default: '0};
  logic signed [DAC_W-1:0] analogOut [NUM_DET];
  logic [NUM_TARGETS-1:0]  targetState;
  logic [NUM_DET-1:0]      autoOffsetPulse;
  logic [NUM_TTL_OUT-1:0]  ttlOut;
  relay_pins_t             relayPins;
  logic                    setGo = 1'b0;
  logic [2:0]              setLine = 3'h0;
  logic                    setLevel = 1'b1;
  logic                    seen;
  int                      errors = 0;
  int                      compares = 0;
  always #5 clock = ~clock;
  instrument_trigger_io_control dut (
    .clock(clock), .srst(srst), .regReq(regReq), .regRdata(regRdata), .trigIn(trigIn),
    .detSample(detSample), .analogOut(analogOut), .targetState(targetState),
    .autoOffsetPulse(autoOffsetPulse), .ttlOut(ttlOut), .relayPins(relayPins));
  trigger_source src (
    .clock(clock), .setGo(setGo), .setLine(setLine), .setLevel(setLevel), .trigIn(trigIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    regReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regReq.rd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rc
  // Moves one pin, then watches the auto-offset pulse for ten cycles.
  task automatic pin(input logic [2:0] n, input logic v);
    @(posedge clock);
    setLine <= n;
    setLevel <= v;
    setGo <= 1'b1;
    @(posedge clock);
    setGo <= 1'b0;
    seen = 1'b0;
    repeat (10) begin
      tick(1);
      seen |= autoOffsetPulse[0];
    end
  endtask : pin
  task automatic pulse(input logic [2:0] n, input logic v);
    pin(n, v);
    tick(1000);
    pin(n, ~v);
  endtask : pulse
  task automatic ao(input logic [31:0] cfg, input logic [31:0] ofs, input logic [31:0] exp);
    wr(OFS_AO_CFG0 + 8'h04, cfg);
    wr(OFS_AO_OFS0 + 8'h04, ofs);
    tick(6);
    chk(32'(analogOut[1]), exp);
  endtask : ao
  task automatic t_reset();
    rc(OFS_IN_MODE, 32'h0);
    rc(OFS_TARGET_ST, 32'h0);
    rc(OFS_AO_CFG0, 32'h0001_0002);
    rc(8'hfc, 32'h0);
    chk({28'h0, relayPins}, 32'h3);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edge();
    wr(OFS_IN_ASSIGN0, 32'h0021_5001);
    pin(3'h0, 1'b0);
    chk(targetState, 32'h0020_1001);
    chk(32'(seen), 32'h1);
    chk(32'(analogOut[0]), 32'h0000_0c80);
    chk({28'h0, relayPins}, 32'h6);
    pin(3'h0, 1'b1);
    chk(targetState, 32'h0);
    chk(32'(seen), 32'h0);
    $display("test normal edge done");
  endtask : t_edge
  task automatic t_inv_edge();
    wr(OFS_IN_MODE, 32'h0000_0004);
    wr(OFS_IN_ASSIGN0 + 8'h04, 32'h0010_0000);
    rc(OFS_IN_MODE, 32'h0000_0004);
    pin(3'h1, 1'b0);
    chk(targetState, 32'h0);
    pin(3'h1, 1'b1);
    chk(targetState, 32'h0010_0000);
    pin(3'h1, 1'b0);
    chk(targetState, 32'h0);
    $display("test inverted edge done");
  endtask : t_inv_edge
  task automatic t_pulse();
    wr(OFS_IN_MODE, 32'h0000_0024);
    wr(OFS_IN_ASSIGN0 + 8'h08, 32'h0004_0000);
    pulse(3'h2, 1'b0);
    chk(targetState, 32'h0);
    wr(OFS_TARGET_SET, 32'h0004_0000);
    pulse(3'h2, 1'b0);
    chk(targetState, 32'h0004_0000);
    $display("test normal pulse done");
  endtask : t_pulse
  task automatic t_ipulse();
    wr(OFS_IN_MODE, 32'h0000_00e4);
    wr(OFS_IN_ASSIGN0 + 8'h0c, 32'h0008_0000);
    wr(OFS_TARGET_SET, 32'h000c_0000);
    pin(3'h3, 1'b0);
    pulse(3'h3, 1'b1);
    chk(targetState, 32'h000c_0000);
    $display("test inverted pulse done");
  endtask : t_ipulse
  task automatic t_analog();
    @(posedge clock);
    detSample[1] <= 16'sd500;
    ao(32'h03e8_0002, 32'd0, 32'h0000_3e80);
    ao(32'h03e8_0012, 32'd0, 32'hffff_c180);
    ao(32'h03e8_0012, 32'd50, 32'h0000_0000);
    ao(32'h03e8_0002, 32'd50, 32'h0000_7d00);
    ao(32'h03e8_0006, 32'd0, 32'h0000_0000);
    ao(32'h03e8_0009, 32'd0, 32'h0000_0c80);
    ao(32'h03e8_0008, 32'd0, 32'h0000_0140);
    $display("test analog done");
  endtask : t_analog
  task automatic t_out();
    wr(OFS_OUT_CTRL, 32'h2);
    wr(OFS_TARGET_SET, 32'h0040_0000);
    tick(2);
    chk(32'(ttlOut), 32'h2);
    chk({28'h0, relayPins}, 32'h9);
    $display("test outputs done");
  endtask : t_out
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_edge();
    t_inv_edge();
    t_pulse();
    t_ipulse();
    t_analog();
    t_out();
    end_sim();
  end
  // Watchdog: the tests need about 3300 cycles.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule : instrument_trigger_io_control_test
`default_nettype wire
